/* src/rss_params.svh */
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define RSS_ADR_CONFIG   8'h00
`define RSS_ADR_FLAGS    8'h04
`define RSS_ADR_STATUS   8'h08
`define RSS_ADR_CLEAR    8'h0c
`define RSS_ADR_ENABLE   8'h10
`define RSS_ADR_KEEP     8'h14
`define RSS_ADR_USER     8'h18

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define RSS_CFG_POWER_UP_TIMER_EN  0
`define RSS_CFG_OSC_LO   1
`define RSS_CFG_OSC_HI   2
`define RSS_CONFIG_RESET 3'h7
`define RSS_USER_RESET   8'h00
`define RSS_FLG_EXPIRY   0
`define RSS_FLG_PDOWN    1
`define RSS_FLG_CHIPRST  2
`define RSS_FLG_POWER_UP_TIMER     3
`define RSS_FLG_OST      4
`define RSS_FLG_MASTER_CLEAR_PIN     5

// ****************************************************************
// Event bits of the status, clear and enable registers
// ****************************************************************
`define RSS_EV_POR       0
`define RSS_EV_MASTER_CLEAR_PIN_RUN  1
`define RSS_EV_MASTER_CLEAR_PIN_SLP  2
`define RSS_EV_WDT_RST   3
`define RSS_EV_WDT_WAKE  4
`define RSS_EV_BROWNOUT  5
`define RSS_EV_PARITY    6
`define RSS_EV_INT_WAKE  7
`define RSS_NUM_EV       8

// ****************************************************************
// Timing
// ****************************************************************
`define RSS_CLK_MHZ       100
`define RSS_POWER_UP_TIMER_MS       72
`define RSS_OST_COUNT     1024
`define RSS_FILTER_NS     200
`define RSS_FILTER_CYCLES ((`RSS_FILTER_NS * `RSS_CLK_MHZ + 999) / 1000)

`endif

/* src/rss_pkg.sv */
package rss_pkg;

	typedef enum logic [3:0] {
		RSS_ST_RUN      = 4'h1,
		RSS_ST_POWER_UP_TIMER     = 4'h2,
		RSS_ST_OST      = 4'h4,
		RSS_ST_WAKE_OST = 4'h8
	} rss_state_e;

	typedef enum logic [1:0] {
		RSS_OSC_LOW_POWER  = 2'h0,
		RSS_OSC_STANDARD   = 2'h1,
		RSS_OSC_HIGH_SPEED = 2'h2,
		RSS_OSC_RES_CAP    = 2'h3
	} rss_osc_e;

endpackage

/* src/rss_filter.sv */
`timescale 1ns/10ps
`include "rss_params.svh"

module rss_filter (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic rst_i,
	// Pin level in and filtered level out
	input  wire logic raw_i,
	output logic      filtered_o
);

	localparam logic [7:0] LAST = 8'(`RSS_FILTER_CYCLES - 1);

	logic [7:0] count;

	// A new level is accepted only after it has stood for the whole
	// filter time; any shorter pulse restarts the count and is dropped.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			filtered_o <= 1'b1;
			count      <= 8'h00;
		end else if (raw_i == filtered_o) begin
			count <= 8'h00;
		end else if (count == LAST) begin
			filtered_o <= raw_i;
			count      <= 8'h00;
		end else begin
			count <= count + 8'h01;
		end
	end

endmodule

/* src/rss_sequencer.sv */
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "rss_params.svh"

// How it works
// - Six reset causes are told apart.
// - Retained register untouched by every reset.
// - Reset-state register reloads on every reset.
// - Watchdog wake-up reinitialises nothing.
// - Expiry and powerdown flags identify reset kind.
// - Flag values per cause, running clear unchanged.
// - Short master-clear pulses are filtered out.
// - Watchdog reset never drives master-clear pin.
// - Supply rise makes a power-on pulse.
// - Power-up timer runs from power-on only.
// - Chip held in reset while power-up timer runs.
// - Configuration bit skips power-up timer.
// - Start-up timer counts 1024 oscillator cycles.
// - Start-up timer: crystal modes, power-on, wake.
// - Clock-out gives oscillator divided by four, RC mode only.
// - Two bits select four oscillator modes.
// - Delays run regardless of master-clear pin.
module rss_sequencer
	import rss_pkg::*;
#(
	parameter int unsigned POWER_UP_TIMER_CYCLES = `RSS_POWER_UP_TIMER_MS * 1000 * `RSS_CLK_MHZ
) (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Reset sources
	input  wire logic        supply_ok_i,
	input  wire logic        master_clear_pin_n_i,
	input  wire logic        watchdog_timeout_i,
	input  wire logic        brownout_reset_i,
	input  wire logic        parity_error_reset_i,
	input  wire logic        wake_interrupt_i,
	input  wire logic        sleeping_i,
	// Oscillator
	input  wire logic        oscillator_input_i,
	output logic             clock_out_pin_o,
	// Results
	output logic             chip_reset_o,
	output logic             core_hold_o,
	output logic             expiry_flag_o,
	output logic             powerdown_flag_o,
	output logic             irq_o
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam logic [10:0] OST_LAST = 11'(`RSS_OST_COUNT - 1);

	rss_state_e                 state;
	rss_state_e                 next_state;
	rss_osc_e                   osc_mode;
	logic [2:0]                 config_reg;
	logic [7:0]                 keep_reg;
	logic [7:0]                 user_reg;
	logic [`RSS_NUM_EV-1:0]     status;
	logic [`RSS_NUM_EV-1:0]     enable;
	logic [`RSS_NUM_EV-1:0]     events;
	logic [31:0]                power_up_timer_count;
	logic [10:0]                ost_count;
	logic                       supply_prev;
	logic                       master_clear_pin_filtered;
	logic                       master_clear_pin_prev;
	logic                       osc_prev;
	logic                       clk_div;
	logic                       crystal;
	logic                       osc_rise;
	logic                       por_pulse;
	logic                       master_clear_pin_fall;
	logic                       wdt_reset;
	logic                       wdt_wake;
	logic                       int_wake;
	logic                       any_reset;
	logic                       power_up_timer_done;
	logic                       ost_done;
	logic                       bus_req;
	logic                       bus_wr;
	logic [31:0]                read_data;

	function automatic logic is_crystal(input rss_osc_e mode);
		return mode != RSS_OSC_RES_CAP;
	endfunction

	function automatic logic wr_hit(input logic [7:0] adr, input logic [7:0] want);
		return adr == want;
	endfunction

	// ****************************************************************
	// Master-clear noise filter
	// ****************************************************************
	rss_filter u_filter (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.raw_i      (master_clear_pin_n_i),
		.filtered_o (master_clear_pin_filtered)
	);

	// ****************************************************************
	// Event decode
	// ****************************************************************
	assign osc_mode  = rss_osc_e'({config_reg[`RSS_CFG_OSC_HI], config_reg[`RSS_CFG_OSC_LO]});
	assign crystal   = is_crystal(osc_mode);
	assign osc_rise  = oscillator_input_i & ~osc_prev;
	assign por_pulse = supply_ok_i & ~supply_prev;
	assign master_clear_pin_fall = ~master_clear_pin_filtered & master_clear_pin_prev;
	assign wdt_reset = watchdog_timeout_i & ~sleeping_i;
	assign wdt_wake  = watchdog_timeout_i & sleeping_i;
	assign int_wake  = wake_interrupt_i & sleeping_i;
	assign any_reset = por_pulse | master_clear_pin_fall | wdt_reset | brownout_reset_i
		| parity_error_reset_i;
	assign power_up_timer_done = power_up_timer_count == POWER_UP_TIMER_CYCLES - 1;
	assign ost_done  = osc_rise && ost_count == OST_LAST;
	assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

	always_comb begin
		events[`RSS_EV_POR]      = por_pulse;
		events[`RSS_EV_MASTER_CLEAR_PIN_RUN] = master_clear_pin_fall & ~sleeping_i;
		events[`RSS_EV_MASTER_CLEAR_PIN_SLP] = master_clear_pin_fall & sleeping_i;
		events[`RSS_EV_WDT_RST]  = wdt_reset;
		events[`RSS_EV_WDT_WAKE] = wdt_wake;
		events[`RSS_EV_BROWNOUT] = brownout_reset_i;
		events[`RSS_EV_PARITY]   = parity_error_reset_i;
		events[`RSS_EV_INT_WAKE] = int_wake;
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			supply_prev <= 1'b0;
			master_clear_pin_prev   <= 1'b1;
			osc_prev    <= 1'b0;
		end else begin
			supply_prev <= supply_ok_i;
			master_clear_pin_prev   <= master_clear_pin_filtered;
			osc_prev    <= oscillator_input_i;
		end
	end

	// ****************************************************************
	// Start-up sequence
	// ****************************************************************
	// The power-on pulse restarts the sequence from any state except RSS_ST_OST
	// with the power-up timer off, where the start-up count runs on; the master-clear
	// level plays no part in it, so timers can expire while the pin is still held low.
	always_comb begin
		next_state = state;
		case (state)
			RSS_ST_RUN: begin
				if (wdt_wake | int_wake | master_clear_pin_fall & sleeping_i) begin
					next_state = crystal ? RSS_ST_WAKE_OST : RSS_ST_RUN;
				end
			end
			RSS_ST_POWER_UP_TIMER: begin
				if (power_up_timer_done) begin
					next_state = crystal ? RSS_ST_OST : RSS_ST_RUN;
				end
			end
			RSS_ST_OST, RSS_ST_WAKE_OST: begin
				if (ost_done) begin
					next_state = RSS_ST_RUN;
				end
			end
			default: begin
				next_state = RSS_ST_RUN;
			end
		endcase
		if (por_pulse) begin
			if (config_reg[`RSS_CFG_POWER_UP_TIMER_EN]) begin
				next_state = RSS_ST_POWER_UP_TIMER;
			end else begin
				next_state = crystal ? RSS_ST_OST : RSS_ST_RUN;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= RSS_ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i || state != RSS_ST_POWER_UP_TIMER || por_pulse) begin
			power_up_timer_count <= 32'h0;
		end else if (!power_up_timer_done) begin
			power_up_timer_count <= power_up_timer_count + 32'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i || next_state != state) begin
			ost_count <= 11'h000;
		end else if (osc_rise) begin
			ost_count <= ost_count + 11'h001;
		end
	end

	// ****************************************************************
	// Reset outputs
	// ****************************************************************
	// The watchdog reset only reaches the internal reset; the pin is an
	// input here and is never driven.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			chip_reset_o <= 1'b1;
			core_hold_o  <= 1'b0;
		end else begin
			chip_reset_o <= ~master_clear_pin_filtered | por_pulse | wdt_reset | brownout_reset_i
				| parity_error_reset_i
				| next_state == RSS_ST_POWER_UP_TIMER | next_state == RSS_ST_OST;
			core_hold_o  <= next_state == RSS_ST_WAKE_OST;
		end
	end

	// ****************************************************************
	// Expiry and powerdown flags
	// ****************************************************************
	// Brown-out leaves both flags alone, as does a running master clear.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			expiry_flag_o    <= 1'b1;
			powerdown_flag_o <= 1'b1;
		end else if (por_pulse | parity_error_reset_i) begin
			expiry_flag_o    <= 1'b1;
			powerdown_flag_o <= 1'b1;
		end else if (wdt_reset) begin
			expiry_flag_o    <= 1'b0;
			powerdown_flag_o <= 1'b1;
		end else if (wdt_wake) begin
			expiry_flag_o    <= 1'b0;
			powerdown_flag_o <= 1'b0;
		end else if (int_wake | master_clear_pin_fall & sleeping_i) begin
			expiry_flag_o    <= 1'b1;
			powerdown_flag_o <= 1'b0;
		end
	end

	// ****************************************************************
	// Clock output
	// ****************************************************************
	// Toggling every second oscillator rise gives one output period per
	// four oscillator periods; the pin is low in crystal modes.
	always_ff @(posedge clock_i) begin
		if (rst_i || crystal) begin
			clk_div         <= 1'b0;
			clock_out_pin_o <= 1'b0;
		end else if (osc_rise) begin
			clk_div <= ~clk_div;
			if (clk_div) begin
				clock_out_pin_o <= ~clock_out_pin_o;
			end
		end
	end

	// ****************************************************************
	// Software registers
	// ****************************************************************
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			config_reg <= `RSS_CONFIG_RESET;
			enable     <= '0;
		end else if (bus_wr) begin
			if (wr_hit(wb_adr_i, `RSS_ADR_CONFIG)) begin
				config_reg <= wb_dat_i[2:0];
			end
			if (wr_hit(wb_adr_i, `RSS_ADR_ENABLE)) begin
				enable <= wb_dat_i[`RSS_NUM_EV-1:0];
			end
		end
	end

	// This register has no reset at all and keeps its value through
	// every reset cause.
	always_ff @(posedge clock_i) begin
		if (bus_wr && wr_hit(wb_adr_i, `RSS_ADR_KEEP)) begin
			keep_reg <= wb_dat_i[7:0];
		end
	end

	// Wake-ups are not in the reset set and leave this register alone.
	always_ff @(posedge clock_i) begin
		if (rst_i || any_reset) begin
			user_reg <= `RSS_USER_RESET;
		end else if (bus_wr && wr_hit(wb_adr_i, `RSS_ADR_USER)) begin
			user_reg <= wb_dat_i[7:0];
		end
	end

	// A cause arriving in the cycle of its clear stays set.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			status <= '0;
		end else if (bus_wr && wr_hit(wb_adr_i, `RSS_ADR_CLEAR)) begin
			status <= (status & ~wb_dat_i[`RSS_NUM_EV-1:0]) | events;
		end else begin
			status <= status | events;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status & enable);
		end
	end

	// ****************************************************************
	// Wishbone read and acknowledge
	// ****************************************************************
	always_comb begin
		read_data = 32'h0;
		case (wb_adr_i)
			`RSS_ADR_CONFIG: begin
				read_data[2:0] = config_reg;
			end
			`RSS_ADR_FLAGS: begin
				read_data[`RSS_FLG_EXPIRY]  = expiry_flag_o;
				read_data[`RSS_FLG_PDOWN]   = powerdown_flag_o;
				read_data[`RSS_FLG_CHIPRST] = chip_reset_o;
				read_data[`RSS_FLG_POWER_UP_TIMER]    = state == RSS_ST_POWER_UP_TIMER;
				read_data[`RSS_FLG_OST]     = state == RSS_ST_OST | state == RSS_ST_WAKE_OST;
				read_data[`RSS_FLG_MASTER_CLEAR_PIN]    = ~master_clear_pin_filtered;
			end
			`RSS_ADR_STATUS: begin
				read_data[`RSS_NUM_EV-1:0] = status;
			end
			`RSS_ADR_ENABLE: begin
				read_data[`RSS_NUM_EV-1:0] = enable;
			end
			`RSS_ADR_KEEP: begin
				read_data[7:0] = keep_reg;
			end
			`RSS_ADR_USER: begin
				read_data[7:0] = user_reg;
			end
			default: begin
				read_data = 32'h0;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				wb_dat_o <= read_data;
			end
		end
	end

endmodule

/* testbench/rss_sequencer_asserts.sv */
`timescale 1ns/10ps

// ****************************************************************
// Port checker
// ****************************************************************
module rss_sequencer_asserts (
	// Clock, reset and bus handshake
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Reset sources
	input wire logic supply_ok_i,
	input wire logic master_clear_pin_n_i,
	input wire logic watchdog_timeout_i,
	input wire logic brownout_reset_i,
	input wire logic parity_error_reset_i,
	input wire logic wake_interrupt_i,
	input wire logic sleeping_i,
	// Results
	input wire logic chip_reset_o,
	input wire logic core_hold_o,
	input wire logic expiry_flag_o,
	input wire logic powerdown_flag_o,
	input wire logic irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);

	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	AST_POWER_ON: assert property ($rose(supply_ok_i) |=>
		chip_reset_o && expiry_flag_o && powerdown_flag_o) else $error("power-on pulse missed");
	AST_WATCHDOG_RESET: assert property (watchdog_timeout_i && !sleeping_i |=>
		chip_reset_o && !expiry_flag_o && powerdown_flag_o) else $error("watchdog reset wrong");
	AST_WATCHDOG_WAKE: assert property (watchdog_timeout_i && sleeping_i && !chip_reset_o |=>
		!chip_reset_o && !expiry_flag_o && !powerdown_flag_o) else $error("watchdog wake wrong");
	AST_INT_WAKE: assert property (wake_interrupt_i && sleeping_i && !watchdog_timeout_i |=>
		expiry_flag_o && !powerdown_flag_o) else $error("interrupt wake flags wrong");
	AST_PARITY: assert property (parity_error_reset_i |=>
		chip_reset_o && expiry_flag_o && powerdown_flag_o) else $error("parity reset wrong");
	AST_SOURCE_HOLD: assert property (brownout_reset_i |=> chip_reset_o)
		else $error("brown-out did not reset");
	AST_RELEASE: assert property ($fell(chip_reset_o) |-> !$past(brownout_reset_i) &&
		!$past(parity_error_reset_i) && $past(master_clear_pin_n_i))
		else $error("early release");

	cover property ($fell(chip_reset_o));
	cover property ($rose(core_hold_o));
	cover property ($rose(irq_o));
endmodule

bind rss_sequencer rss_sequencer_asserts u_rss_sequencer_asserts (.clock_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .supply_ok_i, .master_clear_pin_n_i, .watchdog_timeout_i,
	.brownout_reset_i, .parity_error_reset_i, .wake_interrupt_i, .sleeping_i, .chip_reset_o,
	.core_hold_o, .expiry_flag_o, .powerdown_flag_o, .irq_o);

/* testbench/rss_osc_model.sv */
`timescale 1ns/10ps

// ****************************************************************
// Oscillator and clear pin model
// ****************************************************************
module rss_osc_model (
	// Clock
	input  wire logic clock_i,
	// Controls from the bench
	input  wire logic slow_i,
	input  wire logic hold_low_i,
	// Pins toward the block
	output logic      oscillator_o,
	output logic      master_clear_pin_n_o
);
	logic [2:0] ticks = 3'h0;

	always_ff @(posedge clock_i) begin
		ticks <= ticks + 3'h1;
	end

	// A slow crystal has twice the period.
	assign oscillator_o = slow_i ? ticks[2] : ticks[1];
	// The pin has a pull-up, so it reads high whenever nothing holds it low.
	assign master_clear_pin_n_o = !hold_low_i;
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/10ps
`include "rss_params.svh"

module tb_top;
	import rss_pkg::*;
	localparam int PW = 50;
	logic        clock_i;
	logic        rst_i;
	logic        cyc, stb, we, sup, wdt, bor, par, iw, slp, hold, slow;
	logic        ack, osc, pin, cko, crst, hld, exf, pdf, irq;
	logic [7:0]  adr;
	logic [31:0] dat, rd, q;
	int          n_errors = 0;
	int          n_checks = 0;
	int          n;
	logic [2:0]  cf [6] = '{3'h1, 3'h3, 3'h5, 3'h2, 3'h7, 3'h6};
	int          ex [6] = '{PW + 8192, PW + 4096, PW + 4096, 4096, PW, 0};
	logic [4:0]  drv [5] = '{5'h08, 5'h04, 5'h18, 5'h12, 5'h01};
	int          evb [5] = '{3, 5, 4, 7, 6};
	logic [1:0]  fl [5] = '{2'b01, 2'b01, 2'b00, 2'b10, 2'b11};
	logic        rl [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

	rss_sequencer #(.POWER_UP_TIMER_CYCLES(PW)) u_rss_sequencer (.clock_i(clock_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .supply_ok_i(sup),
		.master_clear_pin_n_i(pin), .watchdog_timeout_i(wdt), .brownout_reset_i(bor),
		.parity_error_reset_i(par), .wake_interrupt_i(iw), .sleeping_i(slp),
		.oscillator_input_i(osc), .clock_out_pin_o(cko), .chip_reset_o(crst),
		.core_hold_o(hld), .expiry_flag_o(exf), .powerdown_flag_o(pdf), .irq_o(irq));
	rss_osc_model u_rss_osc_model (.clock_i(clock_i), .slow_i(slow), .hold_low_i(hold),
		.oscillator_o(osc), .master_clear_pin_n_o(pin));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clock_i);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do begin
			@(posedge clock_i);
			t++;
		end while (ack !== 1'b1 && t < 100);
		rd = q;
		{cyc, stb} <= 2'b00;
		if (t >= 100) n_errors++;
	endtask

	task automatic wait_idle(input int lim);
		n = 0;
		while ((crst | hld) !== 1'b0 && n < lim) begin
			@(posedge clock_i);
			n++;
		end
	endtask

	task automatic power(input logic [2:0] c, input int lim);
		wb(1'b1, `RSS_ADR_CONFIG, {29'h0, c});
		@(posedge clock_i);
		sup <= 1'b0;
		repeat (3) @(posedge clock_i);
		sup <= 1'b1;
		// The power-on pulse reaches the reset output one edge later.
		repeat (2) @(posedge clock_i);
		wait_idle(lim);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		chk({crst, exf, pdf}, 3'h7);
		wait_idle(200);
		chk(n > PW - 10 && n < PW + 10, 1'b1);
		wb(1'b0, `RSS_ADR_CONFIG, 32'h0);
		chk(rd, 32'h7);
		wb(1'b0, `RSS_ADR_USER, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, `RSS_ADR_STATUS, 32'h0);
		chk(rd, 32'h1);
		wb(1'b1, 8'h1c, 32'hff);
		wb(1'b0, 8'h1c, 32'h0);
		chk(rd, 32'h0);
		$display("done reset");
	endtask

	task automatic t_power;
		for (int i = 0; i < 6; i++) begin
			slow <= (i == 0);
			power(cf[i], 20000);
			chk(n > ex[i] - 10 && n < ex[i] + 10, 1'b1);
		end
		slow <= 1'b0;
		hold <= 1'b1;
		power(3'h7, PW + 30);
		chk(crst, 1'b1);
		hold <= 1'b0;
		wait_idle(60);
		chk(n > 17 && n < 27, 1'b1);
		$display("done power");
	endtask

	task automatic t_clkout;
		logic p;
		int k;
		for (int j = 0; j < 2; j++) begin
			if (j == 1) begin
				wb(1'b1, `RSS_ADR_CONFIG, 32'h3);
				repeat (2) @(posedge clock_i);
			end
			k = 0;
			p = cko;
			repeat (256) begin
				@(posedge clock_i);
				if (cko !== p) k++;
				p = cko;
			end
			chk(j == 1 ? k == 0 : k > 30 && k < 34, 1'b1);
		end
		$display("done clock out");
	endtask

	task automatic t_master_clear_pin;
		logic b;
		logic [1:0] f;
		wb(1'b1, `RSS_ADR_USER, 32'h5a);
		wb(1'b1, `RSS_ADR_KEEP, 32'ha5);
		wb(1'b1, `RSS_ADR_CLEAR, 32'hff);
		f = {exf, pdf};
		b = 1'b0;
		hold <= 1'b1;
		repeat (10) @(posedge clock_i);
		hold <= 1'b0;
		repeat (25) begin
			@(posedge clock_i);
			b = b | crst;
		end
		chk(b, 1'b0);
		hold <= 1'b1;
		repeat (40) @(posedge clock_i);
		chk(crst, 1'b1);
		hold <= 1'b0;
		wait_idle(60);
		chk({exf, pdf}, f);
		wb(1'b0, `RSS_ADR_STATUS, 32'h0);
		chk(rd, 32'h2);
		wb(1'b0, `RSS_ADR_USER, 32'h0);
		chk(rd, 32'h0);
		$display("done clear pin");
	endtask

	task automatic t_events;
		wb(1'b1, `RSS_ADR_ENABLE, 32'h8);
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, `RSS_ADR_CLEAR, 32'hff);
			wb(1'b1, `RSS_ADR_USER, 32'h5a);
			@(posedge clock_i);
			{slp, wdt, bor, iw, par} <= drv[i];
			@(posedge clock_i);
			{slp, wdt, bor, iw, par} <= 5'h0;
			repeat (2) @(posedge clock_i);
			chk(hld, drv[i][4]);
			wait_idle(6000);
			chk({exf, pdf}, fl[i]);
			chk(irq, evb[i] == 3);
			wb(1'b0, `RSS_ADR_STATUS, 32'h0);
			chk(rd, 32'h1 << evb[i]);
			wb(1'b0, `RSS_ADR_USER, 32'h0);
			chk(rd, rl[i] ? 32'h0 : 32'h5a);
			wb(1'b0, `RSS_ADR_KEEP, 32'h0);
			chk(rd, 32'ha5);
		end
		$display("done events");
	endtask

	initial begin
		{rst_i, cyc, stb, we, sup, wdt, bor, par, iw, slp, hold, slow} = 12'h880;
		adr = 8'h00;
		dat = 32'h0;
		repeat (4) @(posedge clock_i);
		rst_i <= 1'b0;
		t_reset;
		t_power;
		t_clkout;
		t_master_clear_pin;
		t_events;
		tally_and_finish;
	end

	initial begin
		#500000;
		n_errors++;
		tally_and_finish;
	end
endmodule
